// *** rtl/usc_usart.sv ***
// usc_usart: usart core for collision recovery, sof wake, sample voting
// assumes rxd/txd pads resolved outside; registers over ahb-lite
//
// How it works
// - collision aborts frame, flushes transmit buffer
// - transmitter_enable cleared after sync delay, busy meanwhile
// - txd released on entering collision state, before transmitter disabled
// - collision sets status bit and error flag
// - transmit complete flag set last
// - same pin select loops through pad
// - sof detect only when enable written one
// - falling rx edge requests oscillator and clock
// - sof works in async and sync modes
// - receive start irq raised at start bit
// - without rxs irq, clock held whole frame
// - async mode votes three middle samples
// - sample_adjust zero: 6-7-8 or 2-3-4
// - separate 32-bit rx and tx access enables
// - packed bytes go in ascending order
`timescale 1ns/10ps
module usc_usart
    import usc_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic sys_rst, // async reset, high
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic rxd_in, // receive pad level
    input wire logic sclk_in, // sync mode clock pad
    output logic txd_out, // transmit drive
    output logic txd_oe, // transmit enable
    output logic loop_pad, // rx and tx share one pad
    output logic osc_req, // fast oscillator request
    output logic cpu_wake, // wake request
    output logic irq // level interrupt
);
    import usc_pkg::*;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_COLLISION_DETECTED} usc_tx_t;
    usc_tx_t tx_st_r;

    logic [7:0] control_a_register_r;
    logic [2:0] control_b_register_r;
    logic [1:0] control_c_register_r;
    logic [15:0] baud_r;
    logic [8:0] len_r;
    logic [USC_NIRQ-1:0] iflag_r, imask_r;
    logic collision_detected_r;
    // address phase capture
    logic wr_r, rd_r;
    logic [7:0] a_r;
    // transmit buffer: up to four bytes
    logic [31:0] tbuf_r;
    logic [2:0] tcnt_r;
    logic [7:0] tsh_r;
    logic [2:0] tbit_r;
    logic [15:0] tdiv_r;
    logic [3:0] tph_r;
    logic [3:0] sync_cnt_r;
    logic sync_busy_r;
    // receiver
    logic rx_q_r, rx_busy_r, sc_q_r;
    logic [15:0] rdiv_r;
    logic [3:0] rph_r;
    logic [3:0] rbit_r;
    logic [2:0] vote_r;
    logic [7:0] rsh_r;
    logic [31:0] rbuf_r;
    logic [2:0] rcnt_r;
    logic [8:0] rlen_r;

    wire ovs8 = control_a_register_r[USC_CA_OVS8];
    wire [3:0] ph_last = ovs8 ? 4'h7 : 4'hF;
    wire [3:0] mid = (ovs8 ? 4'h3 : 4'h7) + {2'b00, control_a_register_r[USC_CA_SAMPLE_ADJUST_LO +: 2]};
    wire transmitter_enable = control_b_register_r[USC_CB_TRANSMITTER_ENABLE];
    wire take = hsel & hready & htrans[1];
    wire wide_tx = control_c_register_r[USC_CC_WTX];
    wire wide_rx = control_c_register_r[USC_CC_WRX];
    wire sync_md = control_a_register_r[USC_CA_COMMUNICATION_MODE];
    wire tx_tick = (tdiv_r == 16'h0000);
    wire rx_tick = (rdiv_r == 16'h0000);
    wire driving = (tx_st_r != TX_IDLE) && (tx_st_r != TX_COLLISION_DETECTED);
    wire rx_fall = ~rxd_in & rx_q_r;
    wire sof_hit = control_b_register_r[USC_CB_START_FRAME_DETECT_ENABLE] & ~rx_busy_r & rx_fall;
    // read-back differs from driven bit at mid sample
    wire collision_detected_hit = driving & tx_tick & (tph_r == mid) & (rxd_in != txd_out);
    // end at mid stop bit so a back-to-back start is not missed
    wire rx_end = ~sync_md & rx_tick & (rph_r == mid + 4'h1);
    wire rx_done = rx_busy_r & rx_end & (rbit_r == 4'd9);
    wire [2:0] rx_need = (wide_rx && !(len_r[USC_LN_EN] && rlen_r == 9'h001))
        ? 3'd4 : 3'd1;
    wire [USC_NIRQ-1:0] ev = {collision_detected_hit, sof_hit,
        rx_done && (rcnt_r + 3'd1 >= rx_need), 1'b0};

    // bus address phase
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            a_r <= 8'h00;
        end else begin
            wr_r <= take & hwrite;
            rd_r <= take & ~hwrite;
            if (take) a_r <= haddr[7:0];
        end
    end
    wire wr_ctl = wr_r;

    // control registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            control_a_register_r <= 8'h00;
            control_b_register_r <= 3'h0;
            control_c_register_r <= 2'h0;
            baud_r <= USC_BAUD_RST;
            len_r <= 9'h000;
            imask_r <= '0;
        end else begin
            if (wr_ctl && a_r == USC_CONTROL_A_REGISTER_OFS) control_a_register_r <= hwdata[7:0];
            if (tx_st_r == TX_COLLISION_DETECTED && sync_cnt_r == 4'h0) begin
                control_b_register_r[USC_CB_TRANSMITTER_ENABLE] <= 1'b0;
            end else if (wr_ctl && a_r == USC_CONTROL_B_REGISTER_OFS) begin
                control_b_register_r <= hwdata[2:0];
            end
            if (wr_ctl && a_r == USC_CONTROL_C_REGISTER_OFS) control_c_register_r <= hwdata[1:0];
            if (wr_ctl && a_r == USC_BAUD_OFS) baud_r <= hwdata[15:0];
            // length usable only alongside wide access
            if (wr_ctl && a_r == USC_LEN_OFS) begin
                len_r <= {hwdata[USC_LN_EN] & (wide_tx | wide_rx), hwdata[7:0]};
            end
            if (wr_ctl && a_r == USC_IMASK_OFS) imask_r <= hwdata[USC_NIRQ-1:0];
        end
    end

    // equal pin selects mean loop through the pad
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) loop_pad <= 1'b0;
        else loop_pad <= control_a_register_r[USC_CA_RECEIVE_PIN_SELECT_LO +: 2] ==
            control_a_register_r[USC_CA_TRANSMIT_PIN_SELECT_LO +: 2];
    end

    // transmitter
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_st_r <= TX_IDLE;
            tbuf_r <= 32'h0000_0000;
            tcnt_r <= 3'h0;
            tsh_r <= 8'h00;
            tbit_r <= 3'h0;
            tdiv_r <= 16'h0000;
            tph_r <= 4'h0;
            txd_out <= 1'b1;
            txd_oe <= 1'b0;
            sync_cnt_r <= 4'h0;
            sync_busy_r <= 1'b0;
        end else begin
            tdiv_r <= (tx_tick || tx_st_r == TX_IDLE) ? baud_r : tdiv_r - 16'h0001;
            txd_oe <= transmitter_enable & (tx_st_r != TX_COLLISION_DETECTED);
            if (wr_ctl && a_r == USC_DATA_OFS && tcnt_r == 3'h0 &&
                    tx_st_r != TX_COLLISION_DETECTED) begin
                tbuf_r <= hwdata;
                tcnt_r <= (wide_tx && !(len_r[USC_LN_EN] && len_r[7:0] < 8'h04))
                    ? 3'd4 : 3'd1;
            end
            if (wr_ctl && a_r == USC_CONTROL_B_REGISTER_OFS) sync_busy_r <= 1'b1;
            else if (tx_st_r != TX_COLLISION_DETECTED) sync_busy_r <= 1'b0;
            unique case (tx_st_r)
                TX_IDLE: begin
                    txd_out <= 1'b1;
                    if (transmitter_enable && tcnt_r != 3'h0) begin
                        tsh_r <= tbuf_r[7:0]; // byte 0 first
                        tbuf_r <= {8'h00, tbuf_r[31:8]};
                        tcnt_r <= tcnt_r - 3'h1;
                        tph_r <= 4'h0;
                        tx_st_r <= TX_START;
                        txd_out <= 1'b0;
                    end
                end
                TX_START, TX_DATA, TX_STOP: begin
                    if (collision_detected_hit) begin
                        tx_st_r <= TX_COLLISION_DETECTED; // abort and flush
                        tcnt_r <= 3'h0;
                        tbuf_r <= 32'h0000_0000;
                        sync_busy_r <= 1'b1;
                        sync_cnt_r <= 4'(USC_SYNC_CYC);
                    end else if (tx_tick) begin
                        tph_r <= tph_r + 4'h1;
                        if (tph_r == ph_last) begin
                            tph_r <= 4'h0;
                            if (tx_st_r == TX_START) begin
                                tx_st_r <= TX_DATA;
                                txd_out <= tsh_r[0];
                                tbit_r <= 3'h0;
                            end else if (tx_st_r == TX_DATA) begin
                                tbit_r <= tbit_r + 3'h1;
                                txd_out <= tbit_r == 3'h7 ? 1'b1 : tsh_r[1];
                                tsh_r <= {1'b0, tsh_r[7:1]};
                                if (tbit_r == 3'h7) tx_st_r <= TX_STOP;
                            end else begin
                                tx_st_r <= TX_IDLE;
                            end
                        end
                    end
                end
                TX_COLLISION_DETECTED: begin
                    txd_out <= 1'b1;
                    if (sync_cnt_r != 4'h0) sync_cnt_r <= sync_cnt_r - 4'h1;
                    else begin
                        tx_st_r <= TX_IDLE; // busy drops with transmitter_enable
                        sync_busy_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // receiver with start detect and majority vote
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_q_r <= 1'b1;
            sc_q_r <= 1'b0;
            rx_busy_r <= 1'b0;
            rdiv_r <= 16'h0000;
            rph_r <= 4'h0;
            rbit_r <= 4'h0;
            vote_r <= 3'h0;
            rsh_r <= 8'h00;
            rbuf_r <= 32'h0000_0000;
            rcnt_r <= 3'h0;
            rlen_r <= 9'h000;
        end else begin
            rx_q_r <= rxd_in;
            sc_q_r <= sclk_in;
            rdiv_r <= (rx_tick || !rx_busy_r) ? baud_r : rdiv_r - 16'h0001;
            if (!rx_busy_r) begin
                rph_r <= 4'h0;
                rbit_r <= 4'h0;
                if ((control_b_register_r[USC_CB_RXEN] || control_b_register_r[USC_CB_START_FRAME_DETECT_ENABLE]) && rx_fall)
                    rx_busy_r <= 1'b1;
            end else if (sync_md) begin
                // synchronous mode: sample on rising external clock
                if (sclk_in && !sc_q_r) begin
                    rbit_r <= rbit_r + 4'h1;
                    if (rbit_r >= 4'd1 && rbit_r <= 4'd8)
                        rsh_r <= {rxd_in, rsh_r[7:1]};
                    if (rbit_r == 4'd9) rx_busy_r <= 1'b0;
                end
            end else if (rx_tick) begin
                rph_r <= (rph_r == ph_last) ? 4'h0 : rph_r + 4'h1;
                if (rph_r == mid - 4'h1 || rph_r == mid || rph_r == mid + 4'h1)
                    vote_r <= {vote_r[1:0], rxd_in};
                if (rph_r == ph_last) begin
                    rbit_r <= rbit_r + 4'h1;
                    if (rbit_r >= 4'd1 && rbit_r <= 4'd8)
                        rsh_r <= {(vote_r[0] & vote_r[1]) | (vote_r[1] &
                            vote_r[2]) | (vote_r[0] & vote_r[2]), rsh_r[7:1]};
                end
                if (rx_done) rx_busy_r <= 1'b0;
            end
            if (rx_done) begin
                // byte n lands in lane n
                rbuf_r[{rcnt_r[1:0], 3'b000} +: 8] <= rsh_r;
                rcnt_r <= (rcnt_r + 3'd1 >= rx_need) ? 3'h0 : rcnt_r + 3'd1;
                rlen_r <= (rlen_r == 9'h000) ? 9'h000 : rlen_r - 9'h001;
            end
            if (wr_ctl && a_r == USC_LEN_OFS) rlen_r <= {1'b0, hwdata[7:0]};
        end
    end

    // sticky flags, write one clears, set wins
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            iflag_r <= '0;
            collision_detected_r <= 1'b0;
        end else begin
            for (int i = 0; i < USC_NIRQ; i++) begin
                if (ev[i]) iflag_r[i] <= 1'b1;
                else if (wr_ctl && a_r == USC_IFLAG_OFS && hwdata[i])
                    iflag_r[i] <= 1'b0;
            end
            if (collision_detected_hit) collision_detected_r <= 1'b1;
            else if (wr_ctl && a_r == USC_STAT_OFS && hwdata[0]) collision_detected_r <= 1'b0;
            // buffer empty once the flush completes
            if (tx_st_r == TX_COLLISION_DETECTED && sync_cnt_r == 4'h0)
                iflag_r[USC_IF_TXC] <= 1'b1;
            else if (tx_st_r == TX_STOP && tx_tick && tph_r == ph_last &&
                    tcnt_r == 3'h0)
                iflag_r[USC_IF_TXC] <= 1'b1;
        end
    end

    // outputs and read data
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
            osc_req <= 1'b0;
            cpu_wake <= 1'b0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            irq <= |(iflag_r & imask_r);
            // clock kept for the whole frame
            osc_req <= sof_hit | (control_b_register_r[USC_CB_START_FRAME_DETECT_ENABLE] & rx_busy_r);
            // immediate wake with rxs enabled, else on rx complete
            // level: wake stands until software clears the flag
            cpu_wake <= (sof_hit & imask_r[USC_IF_RXS]) |
                (iflag_r[USC_IF_RXS] & imask_r[USC_IF_RXS]) |
                (iflag_r[USC_IF_RXC] & imask_r[USC_IF_RXC]);
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            if (take && !hwrite) begin
                unique case (haddr[7:0])
                    USC_CONTROL_A_REGISTER_OFS: hrdata <= {24'h0, control_a_register_r};
                    USC_CONTROL_B_REGISTER_OFS: hrdata <= {29'h0, control_b_register_r};
                    USC_CONTROL_C_REGISTER_OFS: hrdata <= {30'h0, control_c_register_r};
                    USC_BAUD_OFS: hrdata <= {16'h0, baud_r};
                    USC_LEN_OFS: hrdata <= {23'h0, len_r};
                    USC_DATA_OFS: hrdata <= wide_rx ? rbuf_r : {24'h0, rbuf_r[7:0]};
                    USC_STAT_OFS: hrdata <= {31'h0, collision_detected_r};
                    USC_IFLAG_OFS: hrdata <= {28'h0, iflag_r};
                    USC_IMASK_OFS: hrdata <= {28'h0, imask_r};
                    USC_SYNC_OFS: hrdata <= {31'h0, sync_busy_r};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    collision_flags_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        collision_detected_hit |=> collision_detected_r && iflag_r[USC_IF_ERR])
        else $error("collision flags not set");
    collision_busy_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        collision_detected_hit |=> sync_busy_r && tcnt_r == 3'h0)
        else $error("collision did not flush or go busy");
    transmitter_enable_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        collision_detected_hit |-> ##[1:20] !transmitter_enable)
        else $error("transmitter_enable not cleared after collision");
    txd_release_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_st_r == TX_COLLISION_DETECTED |=> !txd_oe)
        else $error("txd still driven after collision");
    txc_last_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_st_r == TX_COLLISION_DETECTED && sync_cnt_r == 4'h0 |=> iflag_r[USC_IF_TXC])
        else $error("txc not set after collision");
    sof_osc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        sof_hit |=> osc_req)
        else $error("no oscillator request on start");
    sof_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !control_b_register_r[USC_CB_START_FRAME_DETECT_ENABLE] |-> !sof_hit)
        else $error("start detect while disabled");
    rxs_wake_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        sof_hit && imask_r[USC_IF_RXS] |=> cpu_wake)
        else $error("no immediate wake on start");
    irq_level_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        |(iflag_r & imask_r) |=> irq)
        else $error("irq not raised");
    c_collision_detected: cover property (@(posedge core_clk) collision_detected_hit);
    c_sof: cover property (@(posedge core_clk) sof_hit);
    c_rxdone: cover property (@(posedge core_clk) rx_done && wide_rx);
endmodule

// *** rtl/usc_pkg.sv ***
// usc_pkg: constants for the usart collision / start-of-frame / sampling block
// assumes a single 25 MHz core clock and an AHB-Lite register port
package usc_pkg;
    // register byte addresses
    localparam logic [7:0] USC_CONTROL_A_REGISTER_OFS = 8'h00;
    localparam logic [7:0] USC_CONTROL_B_REGISTER_OFS = 8'h04;
    localparam logic [7:0] USC_CONTROL_C_REGISTER_OFS = 8'h08;
    localparam logic [7:0] USC_BAUD_OFS = 8'h0C;
    localparam logic [7:0] USC_LEN_OFS = 8'h10;
    localparam logic [7:0] USC_DATA_OFS = 8'h14;
    localparam logic [7:0] USC_STAT_OFS = 8'h18;
    localparam logic [7:0] USC_IFLAG_OFS = 8'h1C;
    localparam logic [7:0] USC_IMASK_OFS = 8'h20;
    localparam logic [7:0] USC_SYNC_OFS = 8'h24;
    // control a fields
    localparam int USC_CA_COMMUNICATION_MODE = 0;
    localparam int USC_CA_OVS8 = 1;
    localparam int USC_CA_SAMPLE_ADJUST_LO = 2;
    localparam int USC_CA_RECEIVE_PIN_SELECT_LO = 4;
    localparam int USC_CA_TRANSMIT_PIN_SELECT_LO = 6;
    // control b fields
    localparam int USC_CB_TRANSMITTER_ENABLE = 0;
    localparam int USC_CB_RXEN = 1;
    localparam int USC_CB_START_FRAME_DETECT_ENABLE = 2;
    // control c fields
    localparam int USC_CC_WRX = 0;
    localparam int USC_CC_WTX = 1;
    // length register fields
    localparam int USC_LN_EN = 8;
    // interrupt flag bits
    localparam int USC_IF_TXC = 0;
    localparam int USC_IF_RXC = 1;
    localparam int USC_IF_RXS = 2;
    localparam int USC_IF_ERR = 3;
    localparam int USC_NIRQ = 4;
    // timing
    localparam int USC_CLK_MHZ = 25;
    localparam int USC_SYNC_NS = 120;
    localparam int USC_SYNC_CYC = (USC_SYNC_NS * USC_CLK_MHZ + 999) / 1000;
    localparam logic [15:0] USC_BAUD_RST = 16'h0001;
    localparam logic [1:0] USC_PIN_RST = 2'h0;
endpackage

// *** bench/usc_remote_node.sv ***
// usc_remote_node: far serial node sharing the data line with the device
// assumes one core clock; bit length set by bit_cyc in core clock cycles
`timescale 1ns/10ps
module usc_remote_node (
    input wire logic core_clk, // core clock
    input wire logic txd_out, // device drive level
    input wire logic txd_oe, // device drives the line
    output logic rxd_in // resolved line level
);
    int bit_cyc = 16;
    logic drv; // node drive, low pulls the line down
    logic [7:0] cap;
    logic [7:0] got_q[$]; // bytes seen from the device
    initial drv = 1'b1;
    // pulled-up shared line, device drive loops through the pad
    assign rxd_in = (txd_oe ? txd_out : 1'b1) & drv;
    // only data bits are disturbed: a bent start edge would shift alignment
    task automatic send(input logic [7:0] b, input logic [15:0] bad);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            for (int s = 0; s < bit_cyc; s++) begin
                @(posedge core_clk);
                drv <= f[i] ^ (bad[s] && i > 0 && i < 9);
            end
        end
    endtask
    // pull low over the device's first data bit
    task automatic collide();
        @(negedge rxd_in iff txd_oe);
        repeat (bit_cyc) @(posedge core_clk);
        drv <= 1'b0;
        repeat (bit_cyc) @(posedge core_clk);
        drv <= 1'b1;
    endtask
    always begin
        @(negedge rxd_in iff txd_oe);
        repeat (bit_cyc / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge core_clk);
            cap[i] = rxd_in;
        end
        got_q.push_back(cap);
        repeat (bit_cyc) @(posedge core_clk);
    end
endmodule

// *** bench/test_usart_collision_sof_sampling.sv ***
// test_usart_collision_sof_sampling: register-level tests of usc_usart
// assumes usc_remote_node on the line and hready looped from hreadyout
`timescale 1ns/10ps
module test_usart_collision_sof_sampling;
    import usc_pkg::*;
    localparam logic [31:0] z = 32'h0000_0000;
    localparam logic [31:0] all_m = 32'hFFFF_FFFF;
    logic core_clk, sys_rst, hsel, hwrite, hready, sclk_in;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, rxd_in, txd_out, txd_oe;
    logic loop_pad, osc_req, cpu_wake, irq;
    int fails, checks_done, n;
    assign hready = hreadyout;
    usc_usart dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rxd_in(rxd_in),
        .sclk_in(sclk_in), .txd_out(txd_out), .txd_oe(txd_oe),
        .loop_pad(loop_pad), .osc_req(osc_req), .cpu_wake(cpu_wake),
        .irq(irq));
    usc_remote_node node_u (.core_clk(core_clk), .txd_out(txd_out),
        .txd_oe(txd_oe), .rxd_in(rxd_in));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk; // stands for fast oscillator
    end
    task automatic summarize();
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    // no wait count assumed; a stuck hready is cut off and counted
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] q);
        int k;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        hsize <= 3'b010;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge core_clk);
            k++;
        end while (hready !== 1'b1 && k < 100);
        q = hrdata;
        if (k >= 100)
            fails++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, e);
        xfer(1'b0, a, z, rd);
        cmp(rd & m, e);
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        fails++;
        summarize();
    end
    initial begin
        fails = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = z;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = z;
        sclk_in = 1'b0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        cmp(32'({hresp, irq, txd_oe, txd_out}), 32'h0000_0001);
        rdm(USC_CONTROL_B_REGISTER_OFS, all_m, z);
        rdm(USC_IFLAG_OFS, all_m, z);
        rdm(USC_STAT_OFS, all_m, z);
        rdm(USC_BAUD_OFS, all_m, {16'h0000, USC_BAUD_RST});
        wr(8'h40, all_m);
        rdm(8'h40, all_m, z);
        wr(USC_BAUD_OFS, z);
        wr(USC_CONTROL_A_REGISTER_OFS, 32'h0000_0050);
        tick(2);
        cmp(32'(loop_pad), 32'h0000_0001);
        wr(USC_CONTROL_A_REGISTER_OFS, 32'h0000_0010);
        tick(2);
        cmp(32'(loop_pad), z);
        wr(USC_CONTROL_A_REGISTER_OFS, z);
        // enable bit refused while no wide access is on
        wr(USC_LEN_OFS, 32'h0000_0104);
        rdm(USC_LEN_OFS, all_m, 32'h0000_0004);
        wr(USC_CONTROL_B_REGISTER_OFS, 32'h0000_0002);
        fork
            node_u.send(8'hA5, 16'hE107);
        join_none
        tick(40);
        cmp(32'(osc_req), z);
        wait fork;
        tick(20);
        rdm(USC_DATA_OFS, 32'h0000_00FF, 32'h0000_00A5);
        wr(USC_IFLAG_OFS, 32'h0000_000F);
        wr(USC_IMASK_OFS, 32'h0000_0004);
        wr(USC_CONTROL_B_REGISTER_OFS, 32'h0000_0006);
        fork
            node_u.send(8'h3C, 16'h0000);
        join_none
        tick(8);
        cmp(32'({osc_req, cpu_wake, irq}), 32'h0000_0007);
        wait fork;
        tick(20);
        wr(USC_IFLAG_OFS, 32'h0000_000F);
        wr(USC_IMASK_OFS, 32'h0000_0002);
        xfer(1'b0, USC_DATA_OFS, z, rd);
        fork
            node_u.send(8'h96, 16'h0000);
        join_none
        tick(80);
        cmp(32'({osc_req, cpu_wake}), 32'h0000_0002);
        wait fork;
        tick(20);
        cmp(32'({cpu_wake, irq}), 32'h0000_0003);
        rdm(USC_DATA_OFS, 32'h0000_00FF, 32'h0000_0096);
        wr(USC_IFLAG_OFS, 32'h0000_000F);
        wr(USC_CONTROL_A_REGISTER_OFS, 32'h0000_0002);
        node_u.bit_cyc = 8;
        node_u.send(8'h5A, 16'h0091);
        tick(20);
        rdm(USC_DATA_OFS, 32'h0000_00FF, 32'h0000_005A);
        node_u.bit_cyc = 16;
        wr(USC_CONTROL_A_REGISTER_OFS, z);
        wr(USC_IFLAG_OFS, 32'h0000_000F);
        wr(USC_IMASK_OFS, 32'h0000_0009);
        wr(USC_CONTROL_B_REGISTER_OFS, 32'h0000_0003);
        fork
            node_u.collide();
        join_none
        wr(USC_DATA_OFS, 32'h0000_0055);
        wait fork;
        n = 0;
        do begin
            xfer(1'b0, USC_SYNC_OFS, z, rd);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
        rdm(USC_CONTROL_B_REGISTER_OFS, 32'h0000_0001, z);
        cmp(32'({txd_oe, irq}), 32'h0000_0001);
        rdm(USC_STAT_OFS, 32'h0000_0001, 32'h0000_0001);
        rdm(USC_IFLAG_OFS, 32'h0000_0009, 32'h0000_0009);
        wr(USC_IMASK_OFS, z);
        tick(2);
        cmp(32'(irq), z);
        wr(USC_IMASK_OFS, 32'h0000_0009);
        wr(USC_STAT_OFS, 32'h0000_0001);
        wr(USC_IFLAG_OFS, 32'h0000_000F);
        tick(2);
        cmp(32'(irq), z);
        xfer(1'b0, USC_DATA_OFS, z, rd);
        // let the node finish capturing the aborted frame first
        tick(160);
        node_u.got_q.delete();
        wr(USC_CONTROL_B_REGISTER_OFS, 32'h0000_0001);
        wr(USC_DATA_OFS, 32'h0000_00A3);
        tick(220);
        cmp(32'(node_u.got_q.size()), 32'h0000_0001);
        cmp(32'(node_u.got_q[0]), 32'h0000_00A3);
        rdm(USC_STAT_OFS, all_m, z);
        wr(USC_CONTROL_C_REGISTER_OFS, 32'h0000_0002);
        node_u.got_q.delete();
        wr(USC_DATA_OFS, 32'h4433_2211);
        tick(720);
        cmp(32'(node_u.got_q.size()), 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            cmp(32'(node_u.got_q[i]), 32'h0000_0011 * (i + 1));
        end
        wr(USC_CONTROL_C_REGISTER_OFS, 32'h0000_0001);
        wr(USC_LEN_OFS, 32'h0000_0104);
        rdm(USC_LEN_OFS, all_m, 32'h0000_0104);
        wr(USC_CONTROL_B_REGISTER_OFS, 32'h0000_0002);
        for (int i = 0; i < 4; i++) begin
            node_u.send(8'(8'h11 * (i + 1)), 16'h0000);
        end
        tick(20);
        rdm(USC_DATA_OFS, all_m, 32'h4433_2211);
        // sync mode last: receiver may wait on sclk that never comes
        wr(USC_CONTROL_B_REGISTER_OFS, 32'h0000_0006);
        wr(USC_CONTROL_A_REGISTER_OFS, 32'h0000_0001);
        fork
            node_u.send(8'hC3, 16'h0000);
        join_none
        tick(8);
        cmp(32'(osc_req), 32'h0000_0001);
        wait fork;
        summarize();
    end
endmodule
